// [src/lft_byte_rx.sv]
// Byte receiver: start bit, eight data bits LSB first, stop bit
`timescale 1ns/1ps
module lft_byte_rx
  import lft_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // Normalised line, 1 is recessive
  input  wire logic        rec_i,
  input  wire logic [19:0] period_i,
  // Received byte
  output logic             valid_o,
  output logic [7:0]       byte_o,
  output logic             stop_ok_o,
  output logic             busy_o
);

  typedef enum logic [2:0]
  {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_BITS  = 3'b010,
    RX_STOP  = 3'b011,
    RX_WAIT  = 3'b100
  } lft_rx_st_t;

  lft_rx_st_t  st;
  lft_rx_st_t  next_st;
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic [3:0]  idx;
  logic [3:0]  next_idx;
  logic [7:0]  next_byte;
  logic        next_valid;
  logic        next_stop_ok;

  // Bit timing and shifting, sampled mid bit
  always_comb
  begin
    next_st      = st;
    next_cnt     = (cnt == 20'h0) ? 20'h0 : cnt - 20'h1;
    next_idx     = idx;
    next_byte    = byte_o;
    next_valid   = 1'b0;
    next_stop_ok = stop_ok_o;
    unique case (st)
      RX_IDLE:
        if (!rec_i)
        begin
          next_st  = RX_START;
          next_cnt = {1'b0, period_i[19:1]};
        end
      RX_START:
        if (cnt == 20'h0)
        begin
          next_st  = rec_i ? RX_IDLE : RX_BITS;
          next_cnt = period_i - 20'h1;
          next_idx = 4'h0;
        end
      RX_BITS:
        if (cnt == 20'h0)
        begin
          next_byte = {rec_i, byte_o[7:1]};
          next_idx  = idx + 4'h1;
          next_cnt  = period_i - 20'h1;
          if (idx == 4'h7)
            next_st = RX_STOP;
        end
      RX_STOP:
        if (cnt == 20'h0)
        begin
          next_valid   = 1'b1;
          next_stop_ok = rec_i;
          next_st      = rec_i ? RX_IDLE : RX_WAIT;
        end
      RX_WAIT:
        if (rec_i)
          next_st = RX_IDLE;
      default: next_st = RX_IDLE;
    endcase
  end

  // Receiver registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st        <= RX_IDLE;
      cnt       <= 20'h0;
      idx       <= 4'h0;
      byte_o    <= 8'h0;
      valid_o   <= 1'b0;
      stop_ok_o <= 1'b0;
      busy_o    <= 1'b0;
    end
    else
    begin
      st        <= next_st;
      cnt       <= next_cnt;
      idx       <= next_idx;
      byte_o    <= next_byte;
      valid_o   <= next_valid;
      stop_ok_o <= next_stop_ok;
      busy_o    <= (next_st != RX_IDLE);
    end
  end
endmodule : lft_byte_rx

// [src/lft_decoder.sv]
// Frame trigger decoder top: header, response, errors and trigger events
//
// Functional notes
// - Idle line is recessive logic 1; polarity picks the idle level.
// - Start-of-frame trigger fires at the stop bit of sync byte.
// - Wake-up trigger fires after a complete wake-up pulse.
// - Error trigger fires on any enabled error class, several allowed.
// - Identifier bits 6 and 7 are parity; mismatch flags parity error.
// - Last response byte is the checksum, checked over data (classic) or over data and PROTECTED_IDENTIFIER_BYTE (enhanced).
// - Version setting picks checksum variant, with an any option.
// - Identifier match uses six id bits, never the parity bits.
// - Patterns hold 0, 1 or don't-care per bit, up to 64 bits.
// - Don't-care id pattern allows equal and not-equal; defined adds range.
// - Data pattern length is whole bytes, one to eight bytes.
// - Data compare follows the identifier compare restrictions.
// - Id and data trigger fires at end of last pattern byte.
// - Bit rate from a predefined list or a user bit/s value.
// - Each frame reports start time, id, length, data, checksum, state.
// - Search output reports every matching event, not only the first.
`timescale 1ns/1ps
`include "lft_defines.svh"
module lft_decoder
  import lft_pkg::*;
#(
  parameter int unsigned WAKE_MIN_CYC = `LFT_WAKE_MIN_NS / `LFT_CLK_NS
)
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  // Bus data line
  input  wire logic        lin_line_i,
  // Line configuration
  input  wire logic        idle_high_i,
  input  wire lft_ver_t    version_i,
  input  wire lft_rate_t   rate_sel_i,
  input  wire logic [17:0] user_bps_i,
  // Trigger configuration
  input  wire lft_mode_t   mode_i,
  input  wire lft_err_en_t err_en_i,
  input  wire lft_pat_t    id_pat_i,
  input  wire lft_pat_t    data_pat_i,
  input  wire logic [3:0]  data_len_i,
  input  wire logic        arm_i,
  // Events
  output logic             trigger_o,
  output logic             search_hit_o,
  output logic [15:0]      hit_count_o,
  output logic             armed_o,
  // Frame report
  output logic             frame_valid_o,
  output lft_frame_t       frame_o
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_PID  = 2'b10,
    ST_DATA = 2'b11
  } lft_st_t;

  // Sum with end-around carry
  function automatic logic [7:0] add8c(input logic [7:0] a,
                                       input logic [7:0] b);
    logic [8:0] s;
    s     = {1'b0, a} + {1'b0, b};
    add8c = s[7:0] + {7'h0, s[8]};
  endfunction : add8c

  // Expected parity pair of a six bit identifier
  function automatic logic [1:0] id_parity(input logic [5:0] id);
    id_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                 id[0] ^ id[1] ^ id[2] ^ id[4]};
  endfunction : id_parity

  localparam logic [23:0] WAKE_CYC = 24'(WAKE_MIN_CYC);

  //////////////////////////////////////////////////////////////////////////
  logic        lin_meta;
  logic        lin_sync;
  logic        rec;
  logic        rec_d;
  logic [31:0] bps;
  logic [19:0] period;
  logic [19:0] next_period;
  logic [23:0] brk_cyc;
  logic [23:0] gap_cyc;
  logic [23:0] low_cnt;
  logic [23:0] next_low_cnt;
  logic        brk_end;
  logic        wake_end;

  // Pin synchroniser, starts at the idle level to avoid a false edge
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      lin_meta <= idle_high_i;
      lin_sync <= idle_high_i;
    end
    else
    begin
      lin_meta <= lin_line_i;
      lin_sync <= lin_meta;
    end
  end

  assign rec = idle_high_i ? lin_sync : ~lin_sync;

  // Bit period from the selected rate
  always_comb
  begin
    unique case (rate_sel_i)
      RS_2400:  bps = `LFT_BPS_2400;
      RS_4800:  bps = `LFT_BPS_4800;
      RS_9600:  bps = `LFT_BPS_9600;
      RS_10417: bps = `LFT_BPS_10417;
      RS_19200: bps = `LFT_BPS_19200;
      RS_20000: bps = `LFT_BPS_MAX;
      RS_USER:  bps = (user_bps_i < 18'(`LFT_BPS_MIN)) ? `LFT_BPS_MIN
                                                         : 32'(user_bps_i);
      default:  bps = `LFT_BPS_MAX;
    endcase
    next_period = 20'(32'(`LFT_CLK_HZ) / bps);
  end

  // Low pulse length, break and wake-up detection
  always_comb
  begin
    next_low_cnt = rec ? 24'h0 : ((&low_cnt) ? low_cnt : low_cnt + 24'h1);
    brk_end      = rec & ~rec_d & (low_cnt >= brk_cyc);
    wake_end     = rec & ~rec_d & ~brk_end & (low_cnt >= WAKE_CYC);
  end

  // Timing registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rec_d   <= 1'b1;
      low_cnt <= 24'h0;
      period  <= 20'h1;
      brk_cyc <= 24'hffffff;
      gap_cyc <= 24'hffffff;
    end
    else
    begin
      rec_d   <= rec;
      low_cnt <= next_low_cnt;
      period  <= next_period;
      brk_cyc <= 24'(period * `LFT_BREAK_BITS);
      gap_cyc <= 24'(period * `LFT_GAP_BITS);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        rx_ok;
  logic        rx_busy;
  logic [71:0] shift_in;
  logic [71:0] dsr;
  logic [71:0] next_dsr;
  logic [63:0] len_mask;
  logic        id_match;
  logic        data_match;

  lft_byte_rx u_rx
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .rec_i     (rec),
    .period_i  (period),
    .valid_o   (rx_valid),
    .byte_o    (rx_byte),
    .stop_ok_o (rx_ok),
    .busy_o    (rx_busy)
  );

  // Observed data with the newest byte lowest
  assign shift_in = {dsr[63:0], rx_byte};
  assign len_mask = (data_len_i >= 4'h8) ? 64'hffff_ffff_ffff_ffff
                  : ((64'h1 << {data_len_i, 3'b000}) - 64'h1);

  lft_pattern_cmp u_id_cmp
  (
    .pat_i   (id_pat_i),
    .obs_i   ({58'h0, rx_byte[5:0]}),
    .width_i (`LFT_ID_WIDTH),
    .match_o (id_match)
  );

  lft_pattern_cmp u_data_cmp
  (
    .pat_i   (data_pat_i),
    .obs_i   (shift_in[63:0]),
    .width_i (len_mask),
    .match_o (data_match)
  );

  //////////////////////////////////////////////////////////////////////////
  lft_st_t     st;
  lft_st_t     next_st;
  logic [3:0]  nb;
  logic [3:0]  next_nb;
  logic [7:0]  protected_identifier_byte;
  logic [7:0]  next_pid;
  logic [7:0]  sum_c;
  logic [7:0]  next_sum_c;
  logic [7:0]  sum_e;
  logic [7:0]  next_sum_e;
  logic [7:0]  prev_c;
  logic [7:0]  next_prev_c;
  logic [7:0]  prev_e;
  logic [7:0]  next_prev_e;
  logic        par_err;
  logic        next_par_err;
  logic        id_hit;
  logic        next_id_hit;
  logic [23:0] gap;
  logic [23:0] next_gap;
  logic [31:0] t_start;
  logic [31:0] next_t_start;
  lft_frame_t  next_frame;
  logic        fin;
  logic        syn_err;
  logic        chk_err;
  logic        ok_c;
  logic        ok_e;
  logic        ev_sof;
  logic        ev_id;
  logic        ev_data;
  logic        ev_err;
  logic [31:0] tick;
  logic [31:0] trig_time;

  // Frame decoder
  always_comb
  begin
    next_st      = st;
    next_nb      = nb;
    next_pid     = protected_identifier_byte;
    next_dsr     = dsr;
    next_sum_c   = sum_c;
    next_sum_e   = sum_e;
    next_prev_c  = prev_c;
    next_prev_e  = prev_e;
    next_par_err = par_err;
    next_id_hit  = id_hit;
    next_t_start = t_start;
    next_frame   = frame_o;
    next_gap     = (rx_busy | rx_valid) ? 24'h0
                 : ((&gap) ? gap : gap + 24'h1);
    fin          = (st != ST_IDLE) && (gap >= gap_cyc);
    syn_err      = (st == ST_SYNC) || (st == ST_PID);
    ev_sof       = 1'b0;
    ev_id        = 1'b0;
    ev_data      = 1'b0;
    unique case (st)
      ST_IDLE: ;
      ST_SYNC:
        if (rx_valid)
        begin
          ev_sof  = rx_ok;
          next_st = ST_PID;
          if (!rx_ok || rx_byte != `LFT_SYNC_BYTE)
            fin = 1'b1;
        end
      ST_PID:
        if (rx_valid)
        begin
          syn_err      = !rx_ok;
          fin          = !rx_ok;
          next_pid     = rx_byte;
          next_par_err = id_parity(rx_byte[5:0]) !=
                         {rx_byte[`LFT_PAR1_POS], rx_byte[`LFT_PAR0_POS]};
          next_sum_c   = 8'h0;
          next_sum_e   = rx_byte;
          next_id_hit  = id_match;
          ev_id        = id_match;
          next_st      = ST_DATA;
        end
      ST_DATA:
        if (rx_valid && rx_ok)
        begin
          next_dsr    = shift_in;
          next_nb     = nb + 4'h1;
          next_prev_c = sum_c;
          next_prev_e = sum_e;
          next_sum_c  = add8c(sum_c, rx_byte);
          next_sum_e  = add8c(sum_e, rx_byte);
          ev_data     = id_hit && data_match && (data_len_i != 4'h0)
                        && (next_nb == data_len_i);
          fin         = (next_nb == `LFT_MAX_BYTES);
        end
        else if (rx_valid)
          fin = 1'b1;
    endcase
    // Checksum taken as the last byte, before the newest sum
    ok_c    = add8c(next_prev_c, next_dsr[7:0]) == 8'hff;
    ok_e    = add8c(next_prev_e, next_dsr[7:0]) == 8'hff;
    unique case (version_i)
      LV_13:   chk_err = !ok_c;
      LV_2X:   chk_err = !ok_e;
      default: chk_err = !(ok_c || ok_e);
    endcase
    chk_err = chk_err && (next_nb != 4'h0) && !syn_err;
    ev_err  = fin && ((syn_err && err_en_i.syn) ||
                      (next_par_err && err_en_i.par) ||
                      (chk_err && err_en_i.chk));
    if (fin)
    begin
      next_st              = ST_IDLE;
      next_frame.start_rel = t_start - trig_time;
      next_frame.id        = next_pid[5:0];
      next_frame.len       = (next_nb == 4'h0) ? 4'h0 : next_nb - 4'h1;
      next_frame.data      = next_dsr[71:8];
      next_frame.checksum  = (next_nb == 4'h0) ? 8'h0 : next_dsr[7:0];
      next_frame.state     = syn_err      ? FS_SYNC_ERR
                           : next_par_err ? FS_PAR_ERR
                           : chk_err      ? FS_CHK_ERR : FS_OK;
    end
    // A completed break opens a new header
    if (brk_end)
    begin
      next_st      = ST_SYNC;
      next_nb      = 4'h0;
      next_dsr     = 72'h0;
      next_par_err = 1'b0;
      next_id_hit  = 1'b0;
      next_t_start = tick;
    end
  end

  // Decoder registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st            <= ST_IDLE;
      nb            <= 4'h0;
      protected_identifier_byte           <= 8'h0;
      dsr           <= 72'h0;
      sum_c         <= 8'h0;
      sum_e         <= 8'h0;
      prev_c        <= 8'h0;
      prev_e        <= 8'h0;
      par_err       <= 1'b0;
      id_hit        <= 1'b0;
      gap           <= 24'h0;
      t_start       <= 32'h0;
      frame_o       <= '0;
      frame_valid_o <= 1'b0;
    end
    else
    begin
      st            <= next_st;
      nb            <= next_nb;
      protected_identifier_byte           <= next_pid;
      dsr           <= next_dsr;
      sum_c         <= next_sum_c;
      sum_e         <= next_sum_e;
      prev_c        <= next_prev_c;
      prev_e        <= next_prev_e;
      par_err       <= next_par_err;
      id_hit        <= next_id_hit;
      gap           <= next_gap;
      t_start       <= next_t_start;
      frame_o       <= next_frame;
      frame_valid_o <= fin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  logic        hit;
  logic        next_armed;

  // Event selection, trigger and search outputs
  always_comb
  begin
    unique case (mode_i)
      TM_SOF:     hit = ev_sof;
      TM_WAKE:    hit = wake_end;
      TM_ERROR:   hit = ev_err;
      TM_IDENT:   hit = ev_id;
      TM_ID_DATA: hit = ev_data;
      default:    hit = 1'b0;
    endcase
    next_armed = arm_i | (armed_o & ~hit);
  end

  // Event registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      tick         <= 32'h0;
      trig_time    <= 32'h0;
      trigger_o    <= 1'b0;
      search_hit_o <= 1'b0;
      hit_count_o  <= 16'h0;
      armed_o      <= 1'b1;
    end
    else
    begin
      tick         <= tick + 32'h1;
      trig_time    <= (hit & armed_o) ? tick : trig_time;
      trigger_o    <= hit & armed_o;
      search_hit_o <= hit;
      hit_count_o  <= hit_count_o + {15'h0, hit};
      armed_o      <= next_armed;
    end
  end
endmodule : lft_decoder

// [src/lft_defines.svh]
// Constants of the frame trigger decoder: timing, layout and limits
`ifndef LFT_DEFINES_SVH
`define LFT_DEFINES_SVH

// Clock
`define LFT_CLK_HZ       100000000
`define LFT_CLK_NS       10

// Byte and frame layout
`define LFT_DATA_BITS    8
`define LFT_MAX_BYTES    4'h9
`define LFT_SYNC_BYTE    8'h55
`define LFT_ID_BITS      6
`define LFT_PAR0_POS     6
`define LFT_PAR1_POS     7
`define LFT_PAT_BITS     64
`define LFT_ID_WIDTH     64'h0000_0000_0000_003f

// Line timing in bit times and in nanoseconds
`define LFT_BREAK_BITS   13
`define LFT_GAP_BITS     12
`define LFT_WAKE_MIN_NS  250000

// Predefined bit rates in bit/s
`define LFT_BPS_2400     2400
`define LFT_BPS_4800     4800
`define LFT_BPS_9600     9600
`define LFT_BPS_10417    10417
`define LFT_BPS_19200    19200
`define LFT_BPS_MAX      20000
`define LFT_BPS_MIN      100

`endif

// [src/lft_pattern_cmp.sv]
// Masked pattern compare with equal, not-equal and range tests
`timescale 1ns/1ps
module lft_pattern_cmp
  import lft_pkg::*;
(
  // Pattern and observed value
  input  wire lft_pat_t    pat_i,
  input  wire logic [63:0] obs_i,
  input  wire logic [63:0] width_i,
  // Result
  output logic             match_o
);

  logic [63:0] obs_m;
  logic [63:0] val_m;
  logic [63:0] diff;
  logic        defined;

  // Compare only bits inside the width, care bits only for equal and not-equal
  always_comb
  begin
    obs_m   = obs_i & width_i;
    val_m   = pat_i.value & width_i;
    diff    = (obs_m ^ val_m) & pat_i.care;
    defined = &(pat_i.care | ~width_i);
    unique case (pat_i.op)
      CO_EQ: match_o = (diff == 64'h0);
      CO_NE: match_o = (diff != 64'h0);
      CO_GT: match_o = defined && (obs_m > val_m);
      CO_LT: match_o = defined && (obs_m < val_m);
    endcase
  end
endmodule : lft_pattern_cmp

// [src/lft_pkg.sv]
// Types shared by the frame trigger decoder modules
package lft_pkg;
  `include "lft_defines.svh"

  typedef enum logic [2:0]
  {
    TM_SOF     = 3'b000,
    TM_WAKE    = 3'b001,
    TM_ERROR   = 3'b010,
    TM_IDENT   = 3'b011,
    TM_ID_DATA = 3'b100
  } lft_mode_t;

  typedef enum logic [1:0]
  {
    CO_EQ = 2'b00,
    CO_NE = 2'b01,
    CO_GT = 2'b10,
    CO_LT = 2'b11
  } lft_cmp_op_t;

  typedef enum logic [1:0]
  {
    LV_13  = 2'b00,
    LV_2X  = 2'b01,
    LV_ANY = 2'b10
  } lft_ver_t;

  typedef enum logic [2:0]
  {
    RS_2400  = 3'b000,
    RS_4800  = 3'b001,
    RS_9600  = 3'b010,
    RS_10417 = 3'b011,
    RS_19200 = 3'b100,
    RS_20000 = 3'b101,
    RS_USER  = 3'b110
  } lft_rate_t;

  typedef enum logic [1:0]
  {
    FS_OK       = 2'b00,
    FS_CHK_ERR  = 2'b01,
    FS_PAR_ERR  = 2'b10,
    FS_SYNC_ERR = 2'b11
  } lft_fstate_t;

  typedef struct packed
  {
    logic chk;
    logic par;
    logic syn;
  } lft_err_en_t;

  typedef struct packed
  {
    logic [`LFT_PAT_BITS-1:0] value;
    logic [`LFT_PAT_BITS-1:0] care;
    lft_cmp_op_t              op;
  } lft_pat_t;

  typedef struct packed
  {
    logic [31:0] start_rel;
    logic [5:0]  id;
    logic [3:0]  len;
    logic [63:0] data;
    logic [7:0]  checksum;
    lft_fstate_t state;
  } lft_frame_t;
endpackage : lft_pkg

// [verif/lft_decoder_chk.sv]
// Port checker for the frame trigger decoder
`timescale 1ns/1ps
module lft_decoder_chk
  import lft_pkg::*;
#(
  parameter int unsigned WAKE_MIN_CYC = 25000
)
(
  // Clock, reset, line
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire logic        lin_line_i,
  input wire logic        idle_high_i,
  // Configuration
  input wire lft_mode_t   mode_i,
  input wire logic [3:0]  data_len_i,
  input wire logic        arm_i,
  // Outputs
  input wire logic        trigger_o,
  input wire logic        search_hit_o,
  input wire logic [15:0] hit_count_o,
  input wire logic        armed_o,
  input wire logic        frame_valid_o,
  input wire lft_frame_t  frame_o
);
  logic        rec;
  logic [15:0] rec_run, dom_run, last_dom;
  logic [15:0] next_rec_run, next_dom_run, next_last_dom;

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  assign rec = (lin_line_i == idle_high_i);

  ////////////////////////////////////////////////////////////////////////
  // Run lengths of recessive and dominant line levels
  always_comb
  begin
    next_rec_run  = rec ? rec_run + {15'h0, rec_run != 16'hffff} : 16'h0;
    next_dom_run  = rec ? 16'h0 : dom_run + {15'h0, dom_run != 16'hffff};
    next_last_dom = (rec && dom_run != 16'h0) ? dom_run : last_dom;
  end

  always_ff @(posedge clock_i)
  begin
    rec_run  <= sys_rst_i ? 16'h0 : next_rec_run;
    dom_run  <= sys_rst_i ? 16'h0 : next_dom_run;
    last_dom <= sys_rst_i ? 16'h0 : next_last_dom;
  end

  sequence s_one_shot;
    frame_valid_o ##1 !frame_valid_o;
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_trig_is_hit: assert property (trigger_o |-> search_hit_o)
    else $error("trigger without search hit");
  a_trig_disarm: assert property (trigger_o && !arm_i |=> !armed_o)
    else $error("still armed after trigger");
  a_count_step: assert property ($changed(hit_count_o) |->
    hit_count_o == $past(hit_count_o) + 16'h1)
    else $error("hit count jumped");
  a_sof_stop: assert property (trigger_o && mode_i == TM_SOF |->
    rec_run >= 16'd3 && rec_run < 16'd400)
    else $error("start trigger outside stop bit");
  a_wake_long: assert property (trigger_o && mode_i == TM_WAKE |->
    last_dom >= 16'(WAKE_MIN_CYC) && rec_run < 16'd20)
    else $error("wake trigger on short pulse");
  a_err_frame: assert property (trigger_o && mode_i == TM_ERROR |->
    frame_valid_o && frame_o.state != FS_OK)
    else $error("error trigger on clean frame");
  a_ok_quiet: assert property (frame_valid_o && frame_o.state == FS_OK &&
    mode_i == TM_ERROR |-> !search_hit_o)
    else $error("error hit on clean frame");
  a_valid_pulse: assert property (frame_valid_o |-> s_one_shot)
    else $error("frame valid longer than one cycle");
  a_frame_held: assert property (!frame_valid_o |-> $stable(frame_o))
    else $error("frame report changed without valid");
  a_len_max: assert property (frame_valid_o |-> frame_o.len <= 4'h8)
    else $error("frame length above eight");
  a_idata_len: assert property (trigger_o && mode_i == TM_ID_DATA |->
    data_len_i != 4'h0)
    else $error("id and data trigger with no length");
endmodule : lft_decoder_chk

bind lft_decoder lft_decoder_chk #(.WAKE_MIN_CYC(WAKE_MIN_CYC)) u_chk
(
  .clock_i, .sys_rst_i, .lin_line_i, .idle_high_i, .mode_i, .data_len_i,
  .arm_i, .trigger_o, .search_hit_o, .hit_count_o, .armed_o,
  .frame_valid_o, .frame_o
);

// [verif/lft_lin_node.sv]
// Bus node model: master header and slave response on one line
`timescale 1ns/1ps
module lft_lin_node
#(
  parameter int BIT_NS = 3810
)
(
  // Polarity
  input  wire logic idle_high_i,
  // Bus line, pulled to recessive when released
  output logic      line_o
);
  logic rec = 1'b1;

  // Electrical level from the logical level
  assign line_o = rec ~^ idle_high_i;

  ////////////////////////////////////////////////////////////////////////
  // Hold a level for some bit times
  task automatic hold(input logic lvl, input int bits);
    rec = lvl;
    #(BIT_NS * bits);
  endtask : hold

  // Start bit, data bits LSB first, stop bit, no parity
  task automatic tx_byte(input logic [7:0] b);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++)
      hold(b[i], 1);
    hold(1'b1, 1);
  endtask : tx_byte

  // Break, sync byte, identifier byte
  task automatic header(input logic [7:0] p);
    hold(1'b0, 14);
    hold(1'b1, 1);
    tx_byte(8'h55);
    tx_byte(p);
  endtask : header

  // Dominant wake-up pulse
  task automatic pulse(input int ns);
    rec = 1'b0;
    #(ns);
    rec = 1'b1;
  endtask : pulse
endmodule : lft_lin_node

// [verif/lin_frame_trigger_decoder_test.sv]
// Self-checking bench for the frame trigger decoder
`timescale 1ns/1ps
module lin_frame_trigger_decoder_test;
  import lft_pkg::*;
  localparam int BIT_NS = 3810;

  logic        clock_i     = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic        idle_high_i = 1'b1;
  logic        arm_i       = 1'b0;
  logic        lin_line_i;
  lft_ver_t    version_i   = LV_2X;
  lft_mode_t   mode_i      = TM_SOF;
  lft_err_en_t err_en_i    = 3'b100;
  lft_pat_t    id_pat_i    = '0;
  lft_pat_t    data_pat_i  = '0;
  logic [3:0]  data_len_i  = 4'h0;
  logic        trigger_o, search_hit_o, armed_o, frame_valid_o;
  logic [15:0] hit_count_o;
  lft_frame_t  frame_o, fr;
  int          err_total, n_compared, n_trig, n_base, cyc, t_trig, t_fv;
  logic [31:0] seed;
  logic [5:0]  id;
  logic [15:0] d;

  always #5 clock_i = ~clock_i;

  lft_lin_node #(.BIT_NS(BIT_NS)) node
  (
    .idle_high_i (idle_high_i),
    .line_o      (lin_line_i)
  );

  lft_decoder #(.WAKE_MIN_CYC(200)) dut
  (
    .clock_i, .sys_rst_i, .lin_line_i, .idle_high_i, .version_i,
    .rate_sel_i (RS_USER),
    .user_bps_i (18'h3ffff),
    .mode_i, .err_en_i, .id_pat_i, .data_pat_i, .data_len_i, .arm_i,
    .trigger_o, .search_hit_o, .hit_count_o, .armed_o, .frame_valid_o,
    .frame_o
  );

  ////////////////////////////////////////////////////////////////////////
  // Record trigger pulses and frame reports
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (trigger_o === 1'b1)
    begin
      n_trig <= n_trig + 1;
      t_trig <= cyc;
    end
    if (frame_valid_o === 1'b1)
    begin
      fr   <= frame_o;
      t_fv <= cyc;
    end
  end

  // Pseudo-random numbers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Identifier with its two parity bits on top
  function automatic logic [7:0] protected_identifier_byte(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : protected_identifier_byte

  // Inverted carry sum, enhanced form adds the identifier byte
  function automatic logic [7:0] csum(input logic [7:0] p,
                                      input logic [15:0] dd, input logic enh);
    logic [8:0] s;
    s = enh ? {1'b0, p} : 9'h0;
    s = {1'b0, s[7:0]} + {1'b0, dd[15:8]};
    s = {1'b0, s[7:0]} + {8'h0, s[8]};
    s = {1'b0, s[7:0]} + {1'b0, dd[7:0]};
    s = {1'b0, s[7:0]} + {8'h0, s[8]};
    return ~s[7:0];
  endfunction : csum

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask : do_reset

  // Arm, send one two-byte frame, wait out the gap
  task automatic run_frame(input logic [7:0] flip, input logic enh);
    logic [7:0] p;
    p = protected_identifier_byte(id) ^ flip;
    n_base = n_trig;
    arm_i = 1'b1;
    @(negedge clock_i);
    arm_i = 1'b0;
    node.header(p);
    node.tx_byte(d[15:8]);
    node.tx_byte(d[7:0]);
    node.tx_byte(csum(p, d, enh));
    #(BIT_NS * 14);
    @(negedge clock_i);
  endtask : run_frame

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #980000;
    err_total++;
    final_report();
  end

  // Main sequence
  initial
  begin
    seed = 32'h0000b7d1;
    do_reset();
    // Start-of-frame trigger on a clean enhanced frame
    id = 6'(rnd());
    d = 16'(rnd());
    run_frame(8'h00, 1'b1);
    cmp(n_trig - n_base, 1);
    cmp(t_trig < t_fv, 1);
    cmp(fr.id, id);
    cmp(fr.len, 2);
    cmp(fr.data[15:0], d);
    cmp(fr.checksum, csum(protected_identifier_byte(id), d, 1'b1));
    cmp(fr.state, FS_OK);
    cmp($signed(fr.start_rel) inside {[-4200:-3800]}, 1);
    // Inverted line, classic version, enhanced sum sent
    idle_high_i = 1'b0;
    do_reset();
    cmp(hit_count_o, 0);
    mode_i = TM_ERROR;
    version_i = LV_13;
    err_en_i = 3'b100;
    d = 16'(rnd());
    run_frame(8'h00, 1'b1);
    cmp(n_trig - n_base, 1);
    cmp(fr.state, FS_CHK_ERR);
    // Id and data match on the first byte, parity bit 7 broken
    mode_i = TM_ID_DATA;
    version_i = LV_ANY;
    id_pat_i = {{58'h0, id}, 64'h3f, CO_EQ};
    data_pat_i = {{56'h0, d[15:8]}, 64'hff, CO_EQ};
    data_len_i = 4'h1;
    run_frame(8'h80, 1'b1);
    cmp(n_trig - n_base, 1);
    cmp(t_trig < t_fv, 1);
    cmp(fr.id, id);
    cmp(fr.state, FS_PAR_ERR);
    // Wake-up pulse longer than the minimum, shorter than a break
    mode_i = TM_WAKE;
    n_base = n_trig;
    arm_i = 1'b1;
    @(negedge clock_i);
    arm_i = 1'b0;
    node.pulse(3000);
    #(BIT_NS * 4);
    cmp(n_trig - n_base, 1);
    cmp(hit_count_o, 3);
    final_report();
  end
endmodule : lin_frame_trigger_decoder_test
